/* File: hw/ccp_pkg.sv */
// Constants, types and register map of the card command protocol core.
// Assumes a 200 MHz core clock and a link clock of at most a quarter of it.
package ccp_pkg;

   // ---------------------------------------------------------------
   // Register map (byte addresses)
   // ---------------------------------------------------------------
   localparam logic [7:0] A_STATUS = 8'h00;
   localparam logic [7:0] A_MASK   = 8'h04;
   localparam logic [7:0] A_CSD0   = 8'h08;
   localparam logic [7:0] A_CSD1   = 8'h0C;
   localparam logic [7:0] A_CSD2   = 8'h10;
   localparam logic [7:0] A_CSD3   = 8'h14;
   localparam logic [7:0] A_TIMING = 8'h18;
   localparam logic [7:0] A_INFO   = 8'h1C;
   localparam logic [7:0] A_LCMD   = 8'h20;
   localparam logic [7:0] A_LARG   = 8'h24;
   localparam logic [7:0] A_TAGS   = 8'h28;
   localparam logic [7:0] A_WPROT  = 8'h2C;

   // ---------------------------------------------------------------
   // Status bits and field positions
   // ---------------------------------------------------------------
   localparam int ST_W       = 5;
   localparam int ST_CMD     = 0;
   localparam int ST_ILLEGAL = 1;
   localparam int ST_CRCERR  = 2;
   localparam int ST_TIMEOUT = 3;
   localparam int ST_OPDONE  = 4;
   localparam int TM_AT_LSB  = 0;
   localparam int TM_AC_LSB  = 8;
   localparam int TM_RW_LSB  = 16;
   localparam int TM_ECC_LSB = 20;
   localparam logic [31:0] TIMING_RST = 32'h0002_0A01;
   localparam logic [3:0]  ECC_NONE   = 4'h0;
   localparam logic [3:0]  ECC_BCH    = 4'h1;
   localparam logic [11:0] CLASS_SET  = 12'h0FF;
   localparam logic [11:0] BLK_LEN_RST = 12'h200;

   // ---------------------------------------------------------------
   // Frame layout and command sets
   // ---------------------------------------------------------------
   localparam int FRAME_W = 48;
   localparam logic [6:0] CRC_POLY = 7'h09;
   localparam logic [63:0] LEGAL_SET = 64'h0000_047F_7F17_BE9F;
   localparam logic [63:0] BC_SET    = 64'h0000_0000_0000_8011;
   localparam logic [63:0] BCR_SET   = 64'h0000_0000_0000_0006;
   localparam logic [63:0] ADTC_SET  = 64'h0000_0400_4F16_0800;
   localparam logic [63:0] READ_SET  = 64'h0000_0000_0006_0800;
   localparam logic [63:0] PROG_SET  = 64'h0000_0040_3F10_0000;
   localparam logic [5:0] C_BLKLEN = 6'h10;
   localparam logic [5:0] C_SETWP  = 6'h1C;
   localparam logic [5:0] C_CLRWP  = 6'h1D;
   localparam logic [5:0] C_TSECA  = 6'h20;
   localparam logic [5:0] C_TSECB  = 6'h21;
   localparam logic [5:0] C_USEC   = 6'h22;
   localparam logic [5:0] C_TGRPA  = 6'h23;
   localparam logic [5:0] C_TGRPB  = 6'h24;
   localparam logic [5:0] C_UGRP   = 6'h25;
   localparam logic [5:0] C_ERASE  = 6'h26;
   localparam int SECT_SHIFT = 9;
   localparam int GRP_SHIFT  = 13;
   localparam int WPG_SHIFT  = 14;

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int CLK_PS       = 5000;
   localparam int US_PS        = 1000000;
   localparam int LINK_PS      = 125000;
   localparam int ACCESS_CLOCK_PART_UNIT    = 100;
   localparam int CYC_PER_US   = US_PS / CLK_PS;
   localparam int CYC_PER_ACCESS_CLOCK_PART = ACCESS_CLOCK_PART_UNIT * LINK_PS / CLK_PS;
   localparam int TIMEOUT_MULT = 10;

   typedef enum logic [1:0] {
      CT_BC   = 2'h0,
      CT_BCR  = 2'h1,
      CT_AC   = 2'h2,
      CT_ADTC = 2'h3
   } ccp_ctype_t;

   typedef struct packed {
      logic [5:0]  idx;
      logic [31:0] arg;
      ccp_ctype_t  ctype;
   } ccp_cmd_t;

   typedef enum logic [1:0] {
      RX_IDLE = 2'b01,
      RX_BITS = 2'b10
   } ccp_rx_t;

endpackage

/* File: hw/ccp_core.sv */
// Command receiver, tagging, protection and timeout logic of the card.
// Assumes the host drives link clock and command line; user logic answers.
//
// Contract
// - ECC type field programmable: 0 none, 1 BCH 3-bit, 2-15 reserved.
// - Card data checksum is CRC7 x^7+x^3+1 over bits 127 down to 8.
// - Host starts every exchange; card only reacts, never initiates.
// - Byte is the transfer unit; block lengths are whole bytes.
// - Sectors and groups carry tag bits; one erase clears all tagged.
// - Any non-tag command clears all tags, aborting tag-erase.
// - Each protection group has one protect bit set by special commands.
// - Only the documented command index set is accepted.
// - Supported command class set is reported in card data.
// - Commands are typed bc, bcr, ac or adtc.
// - Frame is 48 bits MSB first with index, argument, CRC7, end one.
// - Operations finish or abort with error within ten typical times.
// - Read delay is sum of time and clock access parts.
// - Program time is read time times the read-to-write factor.
`timescale 1ns/1ps
`default_nettype none
module ccp_core
   import ccp_pkg::*;
#(
   parameter int NUM_SECT = 16,
   parameter int NUM_GRP  = 4,
   parameter int NUM_WPG  = 4
) (
   input  wire logic                core_clk,
   input  wire logic                resetn,
   input  wire logic                link_clk,
   input  wire logic                cmd_line,
   input  wire logic [7:0]          reg_addr,
   input  wire logic [31:0]         reg_wdata,
   input  wire logic                reg_wr,
   input  wire logic                reg_rd,
   output logic      [31:0]         reg_rdata,
   output ccp_cmd_t                 cmd_out,
   output logic                     cmd_valid,
   output logic      [11:0]         blk_len,
   output logic                     erase_go,
   output logic      [NUM_SECT-1:0] erase_sect,
   output logic      [NUM_GRP-1:0]  erase_grp,
   output logic      [NUM_WPG-1:0]  wp_bits,
   input  wire logic                op_done,
   output logic                     op_busy,
   output logic                     op_abort,
   output logic                     irq
);

   // ---------------------------------------------------------------
   // Reset release and pin synchronisers
   // ---------------------------------------------------------------
   logic       rst_s1_r, rst_n;
   logic [1:0] lclk_s_r, cmd_s_r;
   logic       lclk_d_r;

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         rst_s1_r <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_s1_r <= 1'b1;
         rst_n    <= rst_s1_r;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         lclk_s_r <= 2'b00;
         cmd_s_r  <= 2'b11;
         lclk_d_r <= 1'b0;
      end else begin
         lclk_s_r <= {lclk_s_r[0], link_clk};
         cmd_s_r  <= {cmd_s_r[0], cmd_line};
         lclk_d_r <= lclk_s_r[1];
      end
   end

   wire link_rise = lclk_s_r[1] & ~lclk_d_r;
   wire cmd_bit   = cmd_s_r[1];

   // ---------------------------------------------------------------
   // Checksum step
   // ---------------------------------------------------------------
   function automatic logic [6:0] crc_step(input logic [6:0] c,
                                           input logic b);
      logic fb;
      fb = b ^ c[6];
      crc_step = {c[5:0], 1'b0} ^ (fb ? CRC_POLY : 7'h00);
   endfunction

   // ---------------------------------------------------------------
   // Frame receiver
   // ---------------------------------------------------------------
   ccp_rx_t     rx_st_r, rx_st_nxt;
   logic [5:0]  rx_cnt_r;
   logic [47:0] frame_r;
   logic [6:0]  rx_crc_r;
   logic        rx_done_r;

   wire rx_last = (rx_cnt_r == 6'(FRAME_W - 1));

   always_comb begin
      rx_st_nxt = rx_st_r;
      case (rx_st_r)
         RX_IDLE: if (link_rise && !cmd_bit) rx_st_nxt = RX_BITS;
         RX_BITS: if (link_rise && rx_last) rx_st_nxt = RX_IDLE;
         default: rx_st_nxt = RX_IDLE;
      endcase
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_st_r   <= RX_IDLE;
         rx_cnt_r  <= 6'h00;
         frame_r   <= 48'h0;
         rx_crc_r  <= 7'h00;
         rx_done_r <= 1'b0;
      end else begin
         rx_st_r   <= rx_st_nxt;
         rx_done_r <= (rx_st_r == RX_BITS) && link_rise && rx_last;
         if (link_rise && rx_st_nxt == RX_BITS) begin
            frame_r  <= {frame_r[46:0], cmd_bit};
            rx_cnt_r <= (rx_st_r == RX_IDLE) ? 6'h01 : rx_cnt_r + 6'h01;
            if (rx_st_r == RX_IDLE)
               rx_crc_r <= crc_step(7'h00, cmd_bit);
            else if (rx_cnt_r < 6'(FRAME_W - 8))
               rx_crc_r <= crc_step(rx_crc_r, cmd_bit);
         end else if (link_rise && rx_last) begin
            frame_r <= {frame_r[46:0], cmd_bit};
         end
      end
   end

   // ---------------------------------------------------------------
   // Frame decode
   // ---------------------------------------------------------------
   wire [5:0]  f_idx   = frame_r[45:40];
   wire [31:0] f_arg   = frame_r[39:8];
   wire        f_fmt   = !frame_r[47] && frame_r[46] && frame_r[0];
   wire        f_crc   = (frame_r[7:1] == rx_crc_r);
   wire        f_good  = rx_done_r && f_fmt && f_crc;
   wire        f_legal = LEGAL_SET[f_idx];
   wire        f_take  = f_good && f_legal;
   wire        f_tag   = (f_idx >= C_TSECA) && (f_idx <= C_UGRP);
   wire        f_read  = READ_SET[f_idx];
   wire        f_prog  = PROG_SET[f_idx];
   ccp_ctype_t f_type;
   assign f_type = BC_SET[f_idx]   ? CT_BC  :
                   BCR_SET[f_idx]  ? CT_BCR :
                   ADTC_SET[f_idx] ? CT_ADTC : CT_AC;
   wire [31:0] sect_no = f_arg >> SECT_SHIFT;
   wire [31:0] grp_no  = f_arg >> GRP_SHIFT;
   wire [31:0] wpg_no  = f_arg >> WPG_SHIFT;

   // ---------------------------------------------------------------
   // Registers and bus
   // ---------------------------------------------------------------
   logic [ST_W-1:0] status_r, mask_r;
   logic [127:0]    csd_r;
   logic [31:0]     timing_r, larg_r;
   logic [5:0]      lidx_r;
   logic [6:0]      csd_crc;
   logic [ST_W-1:0] ev;

   always_comb begin
      csd_crc = 7'h00;
      for (int i = 127; i >= 8; i--)
         csd_crc = crc_step(csd_crc, csd_r[i]);
   end

   wire [3:0] ecc_type = timing_r[TM_ECC_LSB +: 4];
   wire       ecc_rsv  = (ecc_type != ECC_NONE) && (ecc_type != ECC_BCH);
   wire [11:0] ccc_fld = csd_r[95:84];
   wire wr_st   = reg_wr && (reg_addr == A_STATUS);
   wire wr_tm   = reg_wr && (reg_addr == A_TIMING);
   wire [127:0] csd_nxt = {
      (reg_wr && reg_addr == A_CSD3) ? reg_wdata[31:20] : csd_r[127:116],
      (reg_wr && reg_addr == A_CSD3) ? reg_wdata[19:0]  : csd_r[115:96],
      CLASS_SET,
      (reg_wr && reg_addr == A_CSD2) ? reg_wdata[19:0]  : csd_r[83:64],
      (reg_wr && reg_addr == A_CSD1) ? reg_wdata        : csd_r[63:32],
      (reg_wr && reg_addr == A_CSD0) ? reg_wdata        : csd_r[31:0]};
   wire [31:0] info = {10'h0, ecc_rsv, op_busy, ccc_fld,
                       (csd_r[7:1] == csd_crc), csd_crc};
   logic [NUM_SECT-1:0] sect_tag_r;
   logic [NUM_GRP-1:0]  grp_tag_r;
   wire [31:0] rd_mux =
      (reg_addr == A_STATUS) ? 32'(status_r) :
      (reg_addr == A_MASK)   ? 32'(mask_r)   :
      (reg_addr == A_CSD0)   ? csd_r[31:0]   :
      (reg_addr == A_CSD1)   ? csd_r[63:32]  :
      (reg_addr == A_CSD2)   ? csd_r[95:64]  :
      (reg_addr == A_CSD3)   ? csd_r[127:96] :
      (reg_addr == A_TIMING) ? timing_r      :
      (reg_addr == A_INFO)   ? info          :
      (reg_addr == A_LCMD)   ? {24'h0, cmd_out.ctype, lidx_r} :
      (reg_addr == A_LARG)   ? larg_r        :
      (reg_addr == A_TAGS)   ? {16'(grp_tag_r), 16'(sect_tag_r)} :
      (reg_addr == A_WPROT)  ? 32'(wp_bits)  : 32'h0;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         status_r  <= '0;
         mask_r    <= '0;
         csd_r     <= {32'h0, CLASS_SET, 84'h0};
         timing_r  <= TIMING_RST;
         reg_rdata <= 32'h0;
         irq       <= 1'b0;
      end else begin
         status_r  <= (status_r & ~(wr_st ? reg_wdata[ST_W-1:0] : '0)) | ev;
         csd_r     <= csd_nxt;
         reg_rdata <= reg_rd ? rd_mux : 32'h0;
         irq       <= |(((status_r & ~(wr_st ? reg_wdata[ST_W-1:0] : '0))
                         | ev) & mask_r);
         if (reg_wr && reg_addr == A_MASK)
            mask_r <= reg_wdata[ST_W-1:0];
         if (wr_tm)
            timing_r <= {8'h0, reg_wdata[23:0]};
      end
   end

   // ---------------------------------------------------------------
   // Command execution
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cmd_valid <= 1'b0;
         cmd_out   <= '0;
         lidx_r    <= 6'h00;
         larg_r    <= 32'h0;
         blk_len   <= BLK_LEN_RST;
         erase_go  <= 1'b0;
         erase_sect <= '0;
         erase_grp <= '0;
      end else begin
         cmd_valid <= f_take;
         erase_go  <= f_take && (f_idx == C_ERASE);
         if (f_take) begin
            cmd_out <= '{idx: f_idx, arg: f_arg, ctype: f_type};
            lidx_r  <= f_idx;
            larg_r  <= f_arg;
         end
         if (f_take && f_idx == C_BLKLEN && f_arg[11:0] != 12'h0)
            blk_len <= f_arg[11:0];
         if (f_take && f_idx == C_ERASE) begin
            erase_sect <= sect_tag_r;
            erase_grp  <= grp_tag_r;
         end
      end
   end

   // Tag bits and protection bits, one flop per unit.
   genvar g;
   generate
      for (g = 0; g < NUM_SECT; g++) begin : g_sect
         always_ff @(posedge core_clk or negedge rst_n) begin
            if (!rst_n)
               sect_tag_r[g] <= 1'b0;
            else if (f_take && !f_tag)
               sect_tag_r[g] <= 1'b0;
            else if (f_take && sect_no == 32'(g)) begin
               if (f_idx == C_TSECA || f_idx == C_TSECB)
                  sect_tag_r[g] <= 1'b1;
               else if (f_idx == C_USEC)
                  sect_tag_r[g] <= 1'b0;
            end
         end
      end
      for (g = 0; g < NUM_GRP; g++) begin : g_grp
         always_ff @(posedge core_clk or negedge rst_n) begin
            if (!rst_n)
               grp_tag_r[g] <= 1'b0;
            else if (f_take && !f_tag)
               grp_tag_r[g] <= 1'b0;
            else if (f_take && grp_no == 32'(g)) begin
               if (f_idx == C_TGRPA || f_idx == C_TGRPB)
                  grp_tag_r[g] <= 1'b1;
               else if (f_idx == C_UGRP)
                  grp_tag_r[g] <= 1'b0;
            end
         end
      end
      for (g = 0; g < NUM_WPG; g++) begin : g_wpg
         always_ff @(posedge core_clk or negedge rst_n) begin
            if (!rst_n)
               wp_bits[g] <= 1'b0;
            else if (f_take && wpg_no == 32'(g)) begin
               if (f_idx == C_SETWP)
                  wp_bits[g] <= 1'b1;
               else if (f_idx == C_CLRWP)
                  wp_bits[g] <= 1'b0;
            end
         end
      end
   endgenerate

   // ---------------------------------------------------------------
   // Operation timeout
   // ---------------------------------------------------------------
   logic [31:0] op_cnt_r, op_lim_r;
   wire [31:0] rd_typ = 32'(timing_r[TM_AT_LSB +: 8]) * 32'(CYC_PER_US)
                      + 32'(timing_r[TM_AC_LSB +: 8]) * 32'(CYC_PER_ACCESS_CLOCK_PART);
   wire [31:0] pr_typ = rd_typ << timing_r[TM_RW_LSB +: 3];
   wire [31:0] lim    = 32'(TIMEOUT_MULT) * (f_read ? rd_typ : pr_typ);
   wire        op_go  = f_take && (f_read || f_prog);
   wire        op_end = op_busy && op_done;
   wire        op_to  = op_busy && !op_done && (op_cnt_r >= op_lim_r);

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         op_busy  <= 1'b0;
         op_abort <= 1'b0;
         op_cnt_r <= 32'h0;
         op_lim_r <= 32'h0;
      end else begin
         op_abort <= op_to;
         if (op_go) begin
            op_busy  <= 1'b1;
            op_cnt_r <= 32'h1;
            op_lim_r <= (lim == 32'h0) ? 32'h1 : lim;
         end else if (op_end || op_to) begin
            op_busy  <= 1'b0;
         end else if (op_busy) begin
            op_cnt_r <= op_cnt_r + 32'h1;
         end
      end
   end

   always_comb begin
      ev = '0;
      ev[ST_CMD]     = f_take;
      ev[ST_ILLEGAL] = f_good && !f_legal;
      ev[ST_CRCERR]  = rx_done_r && !(f_fmt && f_crc);
      ev[ST_TIMEOUT] = op_to;
      ev[ST_OPDONE]  = op_end && !op_go;
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   legal_index_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      cmd_valid |-> LEGAL_SET[cmd_out.idx])
      else $error("Unsupported index accepted.");
   illegal_flag_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      (f_good && !f_legal) |=> status_r[ST_ILLEGAL] && !cmd_valid)
      else $error("Illegal index not flagged.");
   frame_shape_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      cmd_valid |-> $past(frame_r[7:1] == rx_crc_r && frame_r[0]))
      else $error("Bad frame accepted.");
   host_bits_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      cmd_valid |-> $past(frame_r[47:46]) == 2'b01)
      else $error("Wrong start or direction bit accepted.");
   reply_only_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      cmd_valid |-> $past(rx_done_r))
      else $error("Command issued without host frame.");
   tag_clear_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      (cmd_valid && !(cmd_out.idx inside {[C_TSECA:C_UGRP]}))
      |-> (sect_tag_r == '0) && (grp_tag_r == '0))
      else $error("Tags survive a non-tag command.");
   erase_set_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      erase_go |-> erase_sect == $past(sect_tag_r)
                   && erase_grp == $past(grp_tag_r))
      else $error("Erase set differs from tags.");
   op_limit_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      (op_busy && !op_done && op_cnt_r >= op_lim_r) |=> !op_busy && op_abort)
      else $error("Operation outlived its timeout.");
   prog_time_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      (op_go && f_prog) |=> op_lim_r == 32'(TIMEOUT_MULT) *
         ($past(rd_typ) << $past(timing_r[TM_RW_LSB +: 3])) || op_lim_r == 1)
      else $error("Program timeout not scaled.");
   ecc_flag_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      info[21] == (ecc_type > ECC_BCH))
      else $error("Reserved ECC type not reported.");

endmodule
`default_nettype wire

/* File: testbench/ccp_host_model.sv */
// Host model: drives the link clock and the command line.
// Assumes the card samples both pins with its own core clock.
`timescale 1ns/1ps
`default_nettype none
module ccp_host_model (
   output logic link_clk,
   output logic cmd_line
);
   // ---------------------------------------------------------------
   // Frame sender
   // ---------------------------------------------------------------
   initial begin
      link_clk = 1'b0;
      cmd_line = 1'b1;
   end
   function automatic logic [6:0] crc7(input logic [119:0] m,
                                       input int         n);
      logic [6:0] c;
      c = 7'h00;
      for (int i = n - 1; i >= 0; i--) begin
         c = {c[5:0], 1'b0} ^ ((m[i] ^ c[6]) ? 7'h09 : 7'h00);
      end
      return c;
   endfunction
   // The clock stands low and the pulled-up line idles high between frames.
   task automatic send(input logic [5:0]  idx,
                       input logic [31:0] arg,
                       input logic [47:0] flip);
      logic [47:0] f;
      f = {2'b01, idx, arg, 8'h01};
      f[7:1] = crc7({80'h0, f[47:8]}, 40);
      f = f ^ flip;
      for (int i = 47; i >= 0; i--) begin
         cmd_line = f[i];
         #62.5 link_clk = 1'b1;
         #62.5 link_clk = 1'b0;
      end
      cmd_line = 1'b1;
   endtask
endmodule
`default_nettype wire

/* File: testbench/tb_top.sv */
// Bench of the card command core: registers, frames, tags and timeouts.
// Assumes the host model drives the link pins asynchronously.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import ccp_pkg::*;
   logic        core_clk, resetn, reg_wr, reg_rd, op_done, irq;
   logic        link_clk, cmd_line, cmd_valid, erase_go, op_busy, op_abort;
   logic [7:0]  reg_addr;
   logic [31:0] reg_wdata, reg_rdata, d, w [4];
   logic [11:0] blk_len;
   logic [15:0] erase_sect, sect_q;
   logic [3:0]  erase_grp, grp_q, wp_bits;
   logic [127:0] card_specific_data;
   logic [47:0] flp [3] = '{48'h4000_0000_0000, 48'h2, 48'h1};
   ccp_cmd_t    cmd_out;
   logic [5:0]  idx;
   int          seed = 26, err_count = 0, samples_checked = 0;
   int          n_cmd = 0, n0, cyc = 0, t_cmd, t_abt;
   ccp_core i_ccp_core (.core_clk, .resetn, .link_clk, .cmd_line,
      .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .cmd_out,
      .cmd_valid, .blk_len, .erase_go, .erase_sect, .erase_grp, .wp_bits,
      .op_done, .op_busy, .op_abort, .irq);
   ccp_host_model i_ccp_host_model (.link_clk, .cmd_line);
   // ---------------------------------------------------------------
   // Clock, monitors and tasks
   // ---------------------------------------------------------------
   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cmd_valid === 1'b1) n_cmd <= n_cmd + 1;
      if (cmd_valid === 1'b1) t_cmd <= cyc;
      if (op_abort === 1'b1) t_abt <= cyc;
      if (erase_go === 1'b1) sect_q <= erase_sect;
      if (erase_go === 1'b1) grp_q <= erase_grp;
   end
   function automatic ccp_ctype_t ctype(input logic [5:0] i);
      if (BC_SET[i]) return CT_BC;
      if (BCR_SET[i]) return CT_BCR;
      return ADTC_SET[i] ? CT_ADTC : CT_AC;
   endfunction
   task automatic chk(input logic [47:0] s, input logic [47:0] e);
      samples_checked++;
      if (s !== e) begin
         err_count++;
         $display("unexpected at %0t: seen %h expected %h", $time, s, e);
      end
   endtask
   task automatic give_verdict;
      $display("compares %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge core_clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= v;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] q);
      @(posedge core_clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 q = reg_rdata;
   endtask
   task automatic frm(input logic [5:0] i, input logic [31:0] a,
                      input logic [47:0] fl);
      i_ccp_host_model.send(i, a, fl);
      repeat (6) @(posedge core_clk);
      op_done <= 1'b1;
      @(posedge core_clk);
      op_done <= 1'b0;
      #1;
   endtask
   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   initial begin
      {resetn, reg_wr, reg_rd, op_done, reg_addr, reg_wdata} = '0;
      repeat (10) @(posedge core_clk);
      resetn <= 1'b1;
      repeat (3) @(posedge core_clk);
      rd(A_TIMING, d);
      chk(d, TIMING_RST);
      rd(8'h3C, d);
      chk(d, 0);
      for (int k = 0; k < 4; k++) begin
         w[k] = $random(seed);
         wr(A_CSD0 + 8'(4 * k), w[k]);
      end
      card_specific_data = {w[3], w[2], w[1], w[0]};
      card_specific_data[95:84] = CLASS_SET;
      rd(A_INFO, d);
      chk(d[6:0], i_ccp_host_model.crc7(card_specific_data[127:8], 120));
      chk(d[19:8], CLASS_SET);
      wr(A_CSD0, {w[0][31:8], d[6:0], 1'b0});
      rd(A_INFO, d);
      chk(d[7], 1);
      for (int k = 2; k >= 1; k--) begin
         wr(A_TIMING, 32'h0000_0A01 | (k << TM_ECC_LSB));
         rd(A_INFO, d);
         chk(d[21], k - 1);
      end
      $display("test registers done");
      for (int k = 0; k < 22; k++) begin
         idx = (k < 2) ? 6'(k * 63) : 6'($random(seed));
         w[0] = $random(seed);
         wr(A_STATUS, 32'h1F);
         n0 = n_cmd;
         frm(idx, w[0], 0);
         chk(n_cmd - n0, LEGAL_SET[idx]);
         rd(A_STATUS, d);
         chk(d[ST_ILLEGAL], !LEGAL_SET[idx]);
         if (LEGAL_SET[idx]) chk(cmd_out, {idx, w[0], ctype(idx)});
      end
      for (int k = 0; k < 3; k++) begin
         wr(A_STATUS, 32'h1F);
         n0 = n_cmd;
         frm(6'd13, 0, flp[k]);
         chk(n_cmd - n0, 0);
         rd(A_STATUS, d);
         chk(d[ST_CRCERR], 1);
      end
      $display("test commands done");
      frm(6'd13, 0, 0);
      wr(A_MASK, 32'h1 << ST_CMD);
      wr(A_STATUS, 32'h1F);
      frm(C_TSECA, 3 << SECT_SHIFT, 0);
      frm(C_TSECB, 5 << SECT_SHIFT, 0);
      frm(C_TGRPA, 1 << GRP_SHIFT, 0);
      frm(C_USEC, 5 << SECT_SHIFT, 0);
      chk(irq, 1);
      rd(A_TAGS, d);
      chk(d, 32'h0002_0008);
      frm(C_ERASE, 0, 0);
      chk({grp_q, sect_q}, 20'h2_0008);
      rd(A_TAGS, d);
      chk(d, 0);
      frm(C_TSECA, 7 << SECT_SHIFT, 0);
      frm(6'd13, 0, 0);
      frm(C_ERASE, 0, 0);
      chk(sect_q, 0);
      wr(A_STATUS, 32'h1F);
      repeat (2) @(posedge core_clk);
      #1 chk(irq, 0);
      frm(C_SETWP, 2 << WPG_SHIFT, 0);
      chk(wp_bits[2], 1);
      frm(C_CLRWP, 2 << WPG_SHIFT, 0);
      chk(wp_bits[2], 0);
      frm(C_BLKLEN, 64, 0);
      chk(blk_len, 64);
      $display("test tags done");
      wr(A_TIMING, 32'h0001_0001);
      for (int k = 0; k < 2; k++) begin
         wr(A_STATUS, 32'h1F);
         i_ccp_host_model.send(k ? 6'd24 : 6'd17, 0, 0);
         chk(op_busy, 1);
         for (n0 = 0; n0 < 5000 && op_abort !== 1'b1; n0++) begin
            @(posedge core_clk);
            #1;
         end
         if (n0 == 5000) err_count++;
         if (n0 == 5000) give_verdict();
         @(posedge core_clk);
         #1 chk((t_abt - t_cmd) inside {[(2000 << k) - 3:(2000 << k) + 3]},
                1);
         chk(op_busy, 0);
         rd(A_STATUS, d);
         chk(d[ST_TIMEOUT], 1);
      end
      $display("test timeouts done");
      give_verdict();
   end
endmodule
`default_nettype wire
